// [common/loop_cfg_defines.svh]
// register offsets, field positions, reset values and timing counts of the loop configuration
`ifndef LOOP_CFG_DEFINES_SVH
`define LOOP_CFG_DEFINES_SVH
// ==========================================================
// register offsets
`define CH1_STEP_CONFIG_OFS 8'h45
`define CH1_FILTER_CONFIG_OFS 8'h46
`define CH0_TIMING_CONFIG_OFS 8'h47
`define CH0_STEP_CONFIG_OFS 8'h48
`define CFG_RESET_VAL 8'h00
// ==========================================================
// step config fields
`define STEP_COARSE_POS 6
`define STEP_MIDDLE_POS 4
`define STEP_START_POS 2
`define STEP_DIV_POS 0
// filter config fields
`define FILT_DEC_POS 5
`define FILT_LINE_POS 3
`define FILT_WAIT_POS 1
`define FILT_HOLD_POS 0
// timing config fields
`define TIM_COARSE_POS 6
`define TIM_MIDDLE_POS 4
`define TIM_FINE_POS 2
`define TIM_DIV_POS 0
// ==========================================================
// start wait times in ns and in clock cycles
`define WAIT_SHORT_NS 20000
`define WAIT_MID_NS 100000
`define WAIT_LONG_NS 200000
`define CLK_PERIOD_NS 10
`define WAIT_SHORT_CYC (`WAIT_SHORT_NS / `CLK_PERIOD_NS)
`define WAIT_MID_CYC (`WAIT_MID_NS / `CLK_PERIOD_NS)
`define WAIT_LONG_CYC (`WAIT_LONG_NS / `CLK_PERIOD_NS)
`endif

// [common/loop_cfg_pkg.sv]
// types of the loop configuration block
package loop_cfg_pkg;
    typedef enum logic [1:0] {PH_WAIT, PH_COARSE, PH_MIDDLE, PH_FINE} phase_e;
    typedef logic [7:0] reg_t;
    typedef logic [9:0] dac_t;
endpackage

// [rtl/power_loop_step_config.sv]
// loop configuration registers and per-channel step schedule for channels 1 and 0
`timescale 1ns/100ps
`include "loop_cfg_defines.svh"

module power_loop_step_config
#(
    parameter int WAIT_SHORT = `WAIT_SHORT_CYC,
    parameter int WAIT_MID = `WAIT_MID_CYC,
    parameter int WAIT_LONG = `WAIT_LONG_CYC
)
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // register port from the serial control interface
    input wire logic [7:0] REG_ADDR,
    input wire loop_cfg_pkg::reg_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output loop_cfg_pkg::reg_t REG_RDATA,
    // loop control inputs
    input wire logic CH0_ENABLE,
    input wire logic CH1_ENABLE,
    input wire logic LINE_CLK_IN,
    input wire logic CH1_STEP_DIR,
    input wire logic CH1_FILTER_TICK,
    input wire loop_cfg_pkg::dac_t CH0_STORED_CURRENT_WORD,
    input wire loop_cfg_pkg::dac_t CH1_STORED_CURRENT_WORD,
    // channel 1 outputs
    output loop_cfg_pkg::dac_t DRIVE_CURRENT_CH1,
    output logic CH1_OUTPUT_ON,
    output logic CH1_LOOP_TICK,
    output logic CH1_DECIMATE_TICK,
    output logic [1:0] CH1_PHASE,
    // channel 0 step schedule outputs
    output logic [5:0] CH0_STEP_SIZE,
    output logic [7:0] CH0_START_FILL,
    output logic [1:0] CH0_START_SEL
);
    import loop_cfg_pkg::*;

    // elaboration check: the waits must be ordered and fit the 16-bit wait counter
    if (WAIT_SHORT < 1 || WAIT_MID < WAIT_SHORT || WAIT_LONG < WAIT_MID || WAIT_LONG > 65535)
    begin : g_wait_range
        $error("wait counts out of range");
    end

    // ==========================================================
    // helper functions
    function automatic logic [5:0] coarse_size(input logic [1:0] c);
        unique case (c)
            2'h0: coarse_size = 6'h01;
            2'h1: coarse_size = 6'h08;
            2'h2: coarse_size = 6'h10;
            2'h3: coarse_size = 6'h20;
        endcase
    endfunction

    function automatic logic [5:0] middle_size(input logic [1:0] c, input logic [5:0] s);
        logic [5:0] m;
        m = c[0] ? (s >> 2) : (s >> 1);
        middle_size = (m == 6'h00) ? 6'h01 : m;  // never a zero step
    endfunction

    function automatic logic [7:0] long_count(input logic [1:0] c);
        unique case (c)
            2'h0: long_count = 8'h00;
            2'h1: long_count = 8'h3f;
            2'h2: long_count = 8'h7f;
            2'h3: long_count = 8'hff;
        endcase
    endfunction

    function automatic logic [7:0] short_count(input logic [1:0] c);
        unique case (c)
            2'h0: short_count = 8'h00;
            2'h1: short_count = 8'h1f;
            2'h2: short_count = 8'h3f;
            2'h3: short_count = 8'h7f;
        endcase
    endfunction

    function automatic logic [3:0] div_ratio(input logic [1:0] c);
        unique case (c)
            2'h0: div_ratio = 4'h0;
            2'h1: div_ratio = 4'h3;
            2'h2: div_ratio = 4'h7;
            2'h3: div_ratio = 4'hf;
        endcase
    endfunction

    // ==========================================================
    // registers
    reg_t ch1_step_config_q;
    reg_t ch1_filter_config_q;
    reg_t ch0_timing_config_q;
    reg_t ch0_step_config_q;
    reg_t rdata_d;

    wire sel_ch1_step = REG_ADDR == `CH1_STEP_CONFIG_OFS;
    wire sel_ch1_filt = REG_ADDR == `CH1_FILTER_CONFIG_OFS;
    wire sel_ch0_tim = REG_ADDR == `CH0_TIMING_CONFIG_OFS;
    wire sel_ch0_step = REG_ADDR == `CH0_STEP_CONFIG_OFS;

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (sel_ch1_step)
            rdata_d = ch1_step_config_q;
        if (sel_ch1_filt)
            rdata_d = ch1_filter_config_q;
        if (sel_ch0_tim)
            rdata_d = ch0_timing_config_q;
        if (sel_ch0_step)
            rdata_d = ch0_step_config_q;
    end

    // host writes and reads, reset to zero
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ch1_step_config_q <= `CFG_RESET_VAL;
            ch1_filter_config_q <= `CFG_RESET_VAL;
            ch0_timing_config_q <= `CFG_RESET_VAL;
            ch0_step_config_q <= `CFG_RESET_VAL;
            REG_RDATA <= 8'h00;
        end
        else
        begin
            if (REG_WR && sel_ch1_step)
                ch1_step_config_q <= REG_WDATA;
            if (REG_WR && sel_ch1_filt)
                ch1_filter_config_q <= {REG_WDATA[7:5], 1'b0, REG_WDATA[3:0]};
            if (REG_WR && sel_ch0_tim)
                ch0_timing_config_q <= REG_WDATA;
            if (REG_WR && sel_ch0_step)
                ch0_step_config_q <= REG_WDATA;
            if (REG_RD)
                REG_RDATA <= rdata_d;
        end
    end

    // ==========================================================
    // field decode
    wire [1:0] ch1_coarse_step = ch1_step_config_q[`STEP_COARSE_POS +: 2];
    wire [1:0] ch1_middle_step = ch1_step_config_q[`STEP_MIDDLE_POS +: 2];
    wire [1:0] ch1_start_value_sel = ch1_step_config_q[`STEP_START_POS +: 2];
    wire [1:0] ch1_loop_clock_divider = ch1_step_config_q[`STEP_DIV_POS +: 2];
    wire [2:0] ch1_filter_decimation = ch1_filter_config_q[`FILT_DEC_POS +: 3];
    wire ch1_line_gate = ch1_filter_config_q[`FILT_LINE_POS];
    wire [1:0] ch1_start_wait = ch1_filter_config_q[`FILT_WAIT_POS +: 2];
    wire ch1_loop_hold = ch1_filter_config_q[`FILT_HOLD_POS];
    wire [1:0] ch0_coarse_phase_count = ch0_timing_config_q[`TIM_COARSE_POS +: 2];
    wire [1:0] ch0_middle_phase_count = ch0_timing_config_q[`TIM_MIDDLE_POS +: 2];
    wire [1:0] ch0_fine_phase_count = ch0_timing_config_q[`TIM_FINE_POS +: 2];
    wire [1:0] ch0_divider_start_count = ch0_timing_config_q[`TIM_DIV_POS +: 2];
    wire [1:0] ch0_coarse_step = ch0_step_config_q[`STEP_COARSE_POS +: 2];
    wire [1:0] ch0_middle_step = ch0_step_config_q[`STEP_MIDDLE_POS +: 2];
    wire [1:0] ch0_start_value_sel = ch0_step_config_q[`STEP_START_POS +: 2];
    wire [1:0] ch0_loop_clock_divider = ch0_step_config_q[`STEP_DIV_POS +: 2];

    // channel 1 step sizes
    wire [5:0] ch1_coarse_size = coarse_size(ch1_coarse_step);
    wire [5:0] ch1_middle_size = middle_size(ch1_middle_step, ch1_coarse_size);

    // channel 1 start wait in cycles
    wire [15:0] ch1_wait_cycles = (ch1_start_wait == 2'h0) ? 16'h0000 :
                                  (ch1_start_wait == 2'h1) ? 16'(WAIT_SHORT) :
                                  (ch1_start_wait == 2'h2) ? 16'(WAIT_MID) :
                                  16'(WAIT_LONG);

    // ==========================================================
    // channel 1 loop state; phase counts shared from channel 0 timing register
    phase_e ph_q;
    phase_e ph_d;
    logic [15:0] wait_q;
    logic [7:0] phase_cnt_q;
    logic [7:0] div_start_q;
    logic [3:0] div_cnt_q;
    logic [6:0] dec_cnt_q;
    logic en_q;

    wire divider_live = div_start_q == long_count(ch0_divider_start_count);
    wire [3:0] div_limit = divider_live ? div_ratio(ch1_loop_clock_divider) : 4'h0;
    wire loop_tick = (ph_q != PH_WAIT) && (div_cnt_q == div_limit);
    wire [6:0] dec_limit = 7'((8'h01 << ch1_filter_decimation) - 8'h01);
    wire coarse_done = phase_cnt_q >= long_count(ch0_coarse_phase_count);
    wire middle_done = phase_cnt_q >= short_count(ch0_middle_phase_count);
    wire step_ok = loop_tick && !ch1_loop_hold && (dec_cnt_q == dec_limit);
    wire [5:0] cur_step = (ph_q == PH_COARSE) ? ch1_coarse_size :
                          (ph_q == PH_MIDDLE) ? ch1_middle_size : 6'h01;
    wire start_edge = CH1_ENABLE && !en_q;

    // phase sequencing
    always_comb
    begin
        ph_d = ph_q;
        unique case (ph_q)
            PH_WAIT: if (CH1_ENABLE && wait_q >= ch1_wait_cycles) ph_d = PH_COARSE;
            PH_COARSE: if (loop_tick && coarse_done) ph_d = PH_MIDDLE;
            PH_MIDDLE: if (loop_tick && middle_done) ph_d = PH_FINE;
            PH_FINE: ph_d = PH_FINE;
        endcase
        if (!CH1_ENABLE)
            ph_d = PH_WAIT;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ph_q <= PH_WAIT;
            en_q <= 1'b0;
            wait_q <= 16'h0000;
            phase_cnt_q <= 8'h00;
            div_start_q <= 8'h00;
            div_cnt_q <= 4'h0;
            dec_cnt_q <= 7'h00;
            DRIVE_CURRENT_CH1 <= 10'h000;
        end
        else
        begin
            ph_q <= ph_d;
            en_q <= CH1_ENABLE;
            wait_q <= (ph_q == PH_WAIT && CH1_ENABLE) ? wait_q + 16'h0001 : 16'h0000;
            phase_cnt_q <= (ph_d != ph_q) ? 8'h00 :
                           (loop_tick && phase_cnt_q != 8'hff) ? phase_cnt_q + 8'h01 : phase_cnt_q;
            if (ph_q == PH_WAIT)
                div_start_q <= 8'h00;
            else if (loop_tick && !divider_live)
                div_start_q <= div_start_q + 8'h01;
            div_cnt_q <= (ph_q == PH_WAIT || loop_tick) ? 4'h0 : div_cnt_q + 4'h1;
            if (loop_tick && !ch1_loop_hold)
                dec_cnt_q <= (dec_cnt_q == dec_limit) ? 7'h00 : dec_cnt_q + 7'h01;
            // start value while waiting, then steps
            if (start_edge)
            begin
                unique case (ch1_start_value_sel)
                    2'h1: DRIVE_CURRENT_CH1 <= DRIVE_CURRENT_CH1;
                    2'h2: DRIVE_CURRENT_CH1 <= CH1_STORED_CURRENT_WORD;
                    default: DRIVE_CURRENT_CH1 <= 10'h000;
                endcase
            end
            else if (step_ok && CH1_FILTER_TICK)
            begin
                if (CH1_STEP_DIR)
                    DRIVE_CURRENT_CH1 <= (DRIVE_CURRENT_CH1 > 10'h3ff - 10'(cur_step)) ?
                                         10'h3ff : DRIVE_CURRENT_CH1 + 10'(cur_step);
                else
                    DRIVE_CURRENT_CH1 <= (DRIVE_CURRENT_CH1 < 10'(cur_step)) ?
                                         10'h000 : DRIVE_CURRENT_CH1 - 10'(cur_step);
            end
        end
    end

    // ==========================================================
    // registered status and channel 0 schedule outputs
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CH1_OUTPUT_ON <= 1'b0;
            CH1_LOOP_TICK <= 1'b0;
            CH1_DECIMATE_TICK <= 1'b0;
            CH1_PHASE <= 2'h0;
            CH0_STEP_SIZE <= 6'h00;
            CH0_START_FILL <= 8'h00;
            CH0_START_SEL <= 2'h0;
        end
        else
        begin
            CH1_OUTPUT_ON <= CH1_ENABLE && (!ch1_line_gate || LINE_CLK_IN);
            CH1_LOOP_TICK <= loop_tick && !ch1_loop_hold;
            CH1_DECIMATE_TICK <= step_ok;
            CH1_PHASE <= ph_q;
            CH0_STEP_SIZE <= CH0_ENABLE ?
                middle_size(ch0_middle_step, coarse_size(ch0_coarse_step)) :
                coarse_size(ch0_coarse_step);
            CH0_START_FILL <= short_count(ch0_fine_phase_count) ^
                              {4'h0, div_ratio(ch0_loop_clock_divider)};
            CH0_START_SEL <= (ch0_start_value_sel == 2'h3) ? 2'h0 : ch0_start_value_sel;
        end
    end

endmodule // power_loop_step_config

// [test/host_model.sv]
// host model that drives the register port of the loop configuration block
`timescale 1ns/100ps
module host_model
(
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output loop_cfg_pkg::reg_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire loop_cfg_pkg::reg_t reg_rdata
);
    import loop_cfg_pkg::*;
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end
    // one eight-bit write; address and data show the inverse once released
    task automatic wr(input logic [7:0] a, input reg_t d);
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'h0};
    endtask
    // one eight-bit read; data is taken once the taking edge has updated it
    task automatic rd(input logic [7:0] a, output reg_t d);
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_rd} = {a, 1'h1};
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_rd} = {~a, 1'h0};
        d = reg_rdata;
    endtask
endmodule // host_model

// [test/power_loop_step_config_checker.sv]
// bound assertions of the loop configuration block
`timescale 1ns/100ps
module power_loop_step_config_checker
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire loop_cfg_pkg::reg_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire loop_cfg_pkg::reg_t REG_RDATA,
    // loop signals
    input wire logic CH0_ENABLE,
    input wire logic CH1_ENABLE,
    input wire logic LINE_CLK_IN,
    input wire logic CH1_OUTPUT_ON,
    input wire logic CH1_LOOP_TICK,
    input wire logic [1:0] CH1_PHASE,
    input wire logic [5:0] CH0_STEP_SIZE,
    input wire logic [1:0] CH0_START_SEL
);
    import loop_cfg_pkg::*;
    // ==========================================================
    // shadow registers; armed_q masks the first edge after reset release
    reg_t s45_q, s46_q, s47_q, s48_q;
    logic armed_q;
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {s45_q, s46_q, s47_q, s48_q} <= 32'h0;
            armed_q <= 1'h0;
        end
        else
        begin
            armed_q <= 1'h1;
            if (REG_WR && REG_ADDR == 8'h45) s45_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h46) s46_q <= REG_WDATA & 8'hef;
            if (REG_WR && REG_ADDR == 8'h47) s47_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h48) s48_q <= REG_WDATA;
        end
    end
    // expected values worked out from the shadow copies
    wire logic [5:0] coarse = (s48_q[7:6] == 2'h0) ? 6'h01 : 6'h04 << s48_q[7:6];
    wire logic [5:0] half = s48_q[4] ? coarse >> 2 : coarse >> 1;
    // the middle step never drops to zero, a coarse step of one stays one
    wire logic [5:0] step_exp = !CH0_ENABLE ? coarse : (half == 6'h00) ? 6'h01 : half;
    wire logic [1:0] sel_exp = (s48_q[3:2] == 2'h3) ? 2'h0 : s48_q[3:2];
    wire logic gate_exp = CH1_ENABLE && (!s46_q[3] || LINE_CLK_IN);
    wire reg_t rd_exp = (REG_ADDR == 8'h45) ? s45_q : (REG_ADDR == 8'h46) ? s46_q :
        (REG_ADDR == 8'h47) ? s47_q : (REG_ADDR == 8'h48) ? s48_q : 8'h00;
    // ==========================================================
    // assertions
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    chk_step_size: assert property (armed_q |-> CH0_STEP_SIZE == $past(step_exp))
        else $error("ch0 step size wrong");
    chk_start_sel: assert property (armed_q |-> CH0_START_SEL == $past(sel_exp))
        else $error("ch0 start select wrong");
    chk_line_gate: assert property (armed_q |-> CH1_OUTPUT_ON == $past(gate_exp))
        else $error("ch1 output gating wrong");
    chk_hold_tick: assert property (s46_q[0] && $past(s46_q[0]) |-> !CH1_LOOP_TICK)
        else $error("loop tick while held");
    chk_read_map: assert property (REG_RD |=> REG_RDATA == $past(rd_exp))
        else $error("read data wrong");
    chk_read_stands: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved");
    chk_phase_order: assert property (CH1_PHASE != $past(CH1_PHASE) |->
        CH1_PHASE == 2'h0 || CH1_PHASE > $past(CH1_PHASE))
        else $error("phase out of order");
    chk_wait_phase: assert property (!$past(CH1_ENABLE, 2) |-> CH1_PHASE == 2'h0)
        else $error("phase left wait while off");
    // main scenarios
    cover property (CH1_PHASE == 2'h3);
    cover property (REG_RD && REG_ADDR == 8'h46);
    cover property ($rose(CH1_OUTPUT_ON));
endmodule // power_loop_step_config_checker

bind power_loop_step_config power_loop_step_config_checker i_power_loop_step_config_checker
(
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CH0_ENABLE(CH0_ENABLE),
    .CH1_ENABLE(CH1_ENABLE), .LINE_CLK_IN(LINE_CLK_IN), .CH1_OUTPUT_ON(CH1_OUTPUT_ON),
    .CH1_LOOP_TICK(CH1_LOOP_TICK), .CH1_PHASE(CH1_PHASE), .CH0_STEP_SIZE(CH0_STEP_SIZE),
    .CH0_START_SEL(CH0_START_SEL)
);

// [test/power_loop_step_config_tb.sv]
// self-checking bench of the loop configuration block
`timescale 1ns/100ps
module power_loop_step_config_tb;
    import loop_cfg_pkg::*;
    // ==========================================================
    // short start waits; ch0 table rows: register values, enable, expected outputs
    localparam int WS = 4, WM = 8, WL = 16;
    typedef struct {reg_t tim; reg_t stp; logic en; logic [5:0] st; logic [7:0] fl;
        logic [1:0] sl;} row_s;
    // fill is the fine count xor the divider terminal count (ratio less one)
    row_s rows [6] = '{'{8'h00, 8'h00, 1'h0, 6'h01, 8'h00, 2'h0},
        '{8'h04, 8'h45, 1'h0, 6'h08, 8'h1c, 2'h1}, '{8'h08, 8'h9a, 1'h1, 6'h04, 8'h38, 2'h2},
        '{8'h0c, 8'hef, 1'h1, 6'h10, 8'h70, 2'h0}, '{8'h0c, 8'hf0, 1'h1, 6'h08, 8'h7f, 2'h0},
        '{8'h00, 8'h40, 1'h1, 6'h04, 8'h00, 2'h0}};
    int waits [4] = '{0, WS, WM, WL};
    logic sys_clk, rst_n, ch0_en, ch1_en, line_clk, step_dir, filt_tick, reg_wr, reg_rd;
    logic out_on, loop_tick, dec_tick;
    logic [7:0] reg_addr, ch0_fill;
    reg_t reg_wdata, reg_rdata, rv;
    dac_t stored0, stored1, drive1, cur;
    logic [1:0] phase, ch0_sel;
    logic [5:0] ch0_step;
    int errors, check_count, n;
    // ==========================================================
    // design and host
    power_loop_step_config #(.WAIT_SHORT(WS), .WAIT_MID(WM), .WAIT_LONG(WL))
        i_power_loop_step_config
    (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CH0_ENABLE(ch0_en),
        .CH1_ENABLE(ch1_en), .LINE_CLK_IN(line_clk), .CH1_STEP_DIR(step_dir),
        .CH1_FILTER_TICK(filt_tick), .CH0_STORED_CURRENT_WORD(stored0),
        .CH1_STORED_CURRENT_WORD(stored1), .DRIVE_CURRENT_CH1(drive1), .CH1_OUTPUT_ON(out_on),
        .CH1_LOOP_TICK(loop_tick), .CH1_DECIMATE_TICK(dec_tick), .CH1_PHASE(phase),
        .CH0_STEP_SIZE(ch0_step), .CH0_START_FILL(ch0_fill), .CH0_START_SEL(ch0_sel)
    );
    host_model i_host_model
    (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );
    // ==========================================================
    // helpers: compare, step k cycles, time a phase, end the run
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'h1)
        begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic span(input logic [1:0] ph, input int len);
        for (n = 0; phase === ph && n < 400; n++) cyc(1);
        chk(n >= len - 2 && n <= len + 2, "phase length");
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // clock and watchdog
    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #50000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        {rst_n, ch0_en, ch1_en, line_clk, step_dir, filt_tick} = 6'h00;
        {stored0, stored1, errors, check_count} = {10'h2aa, 10'h155, 32'h0, 32'h0};
        cyc(6);
        rst_n = 1'h1;
        foreach (rows[i])
        begin
            i_host_model.wr(8'h47, rows[i].tim);
            i_host_model.wr(8'h48, rows[i].stp);
            ch0_en = rows[i].en;
            cyc(2);
            chk(ch0_step === rows[i].st, "step size");
            chk(ch0_fill === rows[i].fl, "start fill");
            chk(ch0_sel === rows[i].sl, "start select");
            i_host_model.rd(8'h48, rv);
            chk(rv === rows[i].stp, "read back");
        end
        $display("table done");
        // ch1 start load, each start wait, then the phase walk
        i_host_model.wr(8'h45, 8'h08);
        i_host_model.wr(8'h47, 8'h50);
        chk(ch0_step === 6'h04 && ch0_sel === 2'h0 && ch0_fill === 8'h00, "ch0 moved");
        for (int c = 0; c < 4; c++)
        begin
            ch1_en = 1'h0;
            i_host_model.wr(8'h46, 8'(c * 2));
            ch1_en = 1'h1;
            span(2'h0, waits[c]);
            chk(drive1 === 10'h155, "start value");
        end
        span(2'h1, 63);
        chk(phase === 2'h2, "no middle phase");
        span(2'h2, 31);
        chk(phase === 2'h3, "no fine phase");
        $display("phase walk done");
        // hold with line gating, then release
        {filt_tick, step_dir, ch1_en} = 3'h6;
        i_host_model.wr(8'h46, 8'h09);
        ch1_en = 1'h1;
        cyc(3);
        cur = drive1;
        repeat (20)
        begin
            cyc(1);
            chk(out_on === line_clk, "gating");
            line_clk = ~line_clk;
        end
        chk(drive1 === cur, "moved while held");
        line_clk = 1'h0;
        i_host_model.wr(8'h46, 8'h00);
        cyc(20);
        chk(drive1 !== cur && out_on === 1'h1, "no update after hold");
        // loop clock divided by four, filter decimation by four
        i_host_model.wr(8'h45, 8'h09);
        i_host_model.wr(8'h46, 8'h40);
        n = 0;
        rv = 8'h00;
        repeat (64)
        begin
            cyc(1);
            n += loop_tick;
            rv += dec_tick;
        end
        chk(n >= 15 && n <= 17, "divided loop tick");
        chk(rv >= 8'h03 && rv <= 8'h05, "decimated tick");
        $display("hold done");
        // mid-run reset, masked bit and unmapped place
        rst_n = 1'h0;
        cyc(2);
        rst_n = 1'h1;
        for (int a = 8'h45; a <= 8'h48; a++)
        begin
            i_host_model.rd(8'(a), rv);
            chk(rv === 8'h00, "reset value");
        end
        i_host_model.wr(8'h46, 8'hff);
        i_host_model.rd(8'h46, rv);
        chk(rv === 8'hef, "reserved bit");
        i_host_model.wr(8'h49, 8'h5a);
        i_host_model.rd(8'h49, rv);
        chk(rv === 8'h00, "unmapped read");
        $display("reset done");
        finish_test();
    end
endmodule // power_loop_step_config_tb
